// ### flash_seq_pkg.sv
// constants shared by the sector erase and suspend sequencer
package flash_seq_pkg;

	// clock and timing
	localparam int unsigned CLOCK_PERIOD_NS          = 20;
	localparam int unsigned RESET_RECOVERY_NS        = 200;
	localparam int unsigned ERASE_SUSPEND_LATENCY_NS = 400;
	// least time rounds up, longest time rounds down, never below one cycle
	localparam int unsigned RESET_RECOVERY_CYC =
		(RESET_RECOVERY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int unsigned SUSPEND_RAW_CYC = ERASE_SUSPEND_LATENCY_NS / CLOCK_PERIOD_NS;
	localparam int unsigned ERASE_SUSPEND_CYC = (SUSPEND_RAW_CYC < 1) ? 1 : SUSPEND_RAW_CYC;

	// apb register byte offsets
	localparam logic [7:0] OFF_WRITE_CYCLE = 8'h00;
	localparam logic [7:0] OFF_ADDRESS     = 8'h04;
	localparam logic [7:0] OFF_READ_DATA   = 8'h08;
	localparam logic [7:0] OFF_STATUS      = 8'h0c;
	localparam logic [7:0] OFF_PROTECT     = 8'h10;
	localparam logic [7:0] OFF_MODE        = 8'h14;

	// command bytes and unlock addresses
	localparam logic [7:0]  CMD_UNLOCK1       = 8'haa;
	localparam logic [7:0]  CMD_UNLOCK2       = 8'h55;
	localparam logic [7:0]  CMD_ERASE_SETUP   = 8'h80;
	localparam logic [7:0]  CMD_SECTOR_ERASE  = 8'h30;
	localparam logic [7:0]  CMD_PROGRAM       = 8'ha0;
	localparam logic [7:0]  CMD_SSR_ENTRY     = 8'h88;
	localparam logic [7:0]  CMD_OVERLAY_ENTRY = 8'he0;
	localparam logic [7:0]  CMD_STATUS_READ   = 8'h70;
	localparam logic [7:0]  CMD_STATUS_CLEAR  = 8'h71;
	localparam logic [7:0]  CMD_SUSPEND       = 8'hb0;
	localparam logic [7:0]  CMD_RESUME        = 8'h30;
	localparam logic [7:0]  CMD_RESET         = 8'hf0;
	localparam logic [11:0] ADDR_UNLOCK1      = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK2      = 12'h2aa;

	// status word layout
	localparam int unsigned SR_READY  = 7;
	localparam int unsigned SR_ESUSP  = 6;
	localparam int unsigned SR_EFAIL  = 5;
	localparam int unsigned SR_PFAIL  = 4;
	localparam int unsigned SR_LOCKED = 1;

	// array patterns
	localparam logic [15:0] ERASED_WORD  = 16'hffff;
	localparam logic [15:0] PREPROG_WORD = 16'h0000;

	// controller states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PREPROG,
		ST_ERASE,
		ST_SUSPENDING,
		ST_SUSPENDED,
		ST_SUSP_PROG,
		ST_SUSP_FAIL,
		ST_PROG
	} ctl_state_t;

endpackage

// ### sector_erase_suspend_sequencer.sv
// embedded algorithm controller for sector erase, suspend and resume, apb slave
//
// What this block does
// - preprogram sector to zeros, then erase to ffff
// - while erasing accept only status read, suspend
// - hardware reset stops erase, read mode after recovery
// - protected sector erase aborts and flags failure
// - suspend honoured only during running erase
// - suspend halts erase within latency, then suspended
// - suspended sector reads are undetermined, others normal
// - status shows erasing versus suspended, program result
// - program during suspend returns to suspended state
// - clear or reset after failure returns suspended
// - suspended mode accepts only the listed commands
// - resume restarts erase, repeats ignored, resuspend allowed
// - overlay entry refused while suspended
// - ready flag one only when nothing runs
// - suspended flag set while suspended, resume clears
// - locked flag records lock failure of last operation
// - program to suspended sector sets program fail
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps

module sector_erase_suspend_sequencer #(
	parameter int unsigned SECTORS      = 4,
	parameter int unsigned SECTOR_WORDS = 8,
	parameter int unsigned STEP_CYCLES  = 4,
	parameter int unsigned PROG_CYCLES  = 4
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	localparam int unsigned WORDS = SECTORS * SECTOR_WORDS;
	localparam int unsigned IDX_W = $clog2(WORDS);
	localparam int unsigned SW_W  = $clog2(SECTOR_WORDS);
	localparam int unsigned SEC_W = $clog2(SECTORS);
	localparam logic [SW_W-1:0] LAST_WORD = SW_W'(SECTOR_WORDS - 1);

	// word index of a bus address
	function automatic logic [IDX_W-1:0] word_of(input logic [11:0] a);
		return a[IDX_W-1:0];
	endfunction

	// sector index of a bus address
	function automatic logic [SEC_W-1:0] sector_of(input logic [11:0] a);
		return a[IDX_W-1:SW_W];
	endfunction

	// sector guarded by its dynamic or persistent bit
	function automatic logic is_protected(input logic [SECTORS-1:0] d,
		input logic [SECTORS-1:0] p, input logic [SEC_W-1:0] s);
		return d[s] | p[s];
	endfunction

	flash_seq_pkg::ctl_state_t state, next_state;
	logic [2:0]         cyc, next_cyc;
	logic               pend_prog, next_pend_prog;
	logic [SEC_W-1:0]   esect, next_esect;
	logic               phase, next_phase;
	logic [SW_W-1:0]    wptr, next_wptr;
	logic [15:0]        timer, next_timer;
	logic [15:0]        scnt, next_scnt;
	logic [15:0]        rec_cnt, next_rec_cnt;
	logic               stat_ovl, next_stat_ovl;
	logic               ssr_mode, next_ssr_mode;
	logic               ovl_mode, next_ovl_mode;
	logic               efail, next_efail;
	logic               pfail, next_pfail;
	logic               locked, next_locked;
	logic [SECTORS-1:0] dyn_prot, next_dyn_prot;
	logic [SECTORS-1:0] pers_prot, next_pers_prot;
	logic [11:0]        addr_reg, next_addr_reg;
	logic [IDX_W-1:0]   prog_word, next_prog_word;
	logic [15:0]        prog_data, next_prog_data;
	logic [31:0]        next_prdata;
	logic               next_pslverr;
	logic [15:0]        mem [WORDS];
	logic               mem_we;
	logic [IDX_W-1:0]   mem_wa;
	logic [15:0]        mem_wd;
	logic               ready, esusp, wr_cyc, is555, is2aa;
	logic [7:0]         cmd;
	logic [15:0]        status;
	logic [SEC_W-1:0]   tsect;

	assign pready = 1'b1;

	// live flags and the status word built from them
	always_comb begin
		ready = !(state == flash_seq_pkg::ST_PREPROG || state == flash_seq_pkg::ST_ERASE ||
			state == flash_seq_pkg::ST_SUSPENDING || state == flash_seq_pkg::ST_PROG ||
			state == flash_seq_pkg::ST_SUSP_PROG);
		esusp = state == flash_seq_pkg::ST_SUSPENDED || state == flash_seq_pkg::ST_SUSP_PROG ||
			state == flash_seq_pkg::ST_SUSP_FAIL;
		status = 16'h0000;
		status[flash_seq_pkg::SR_READY]  = ready;
		status[flash_seq_pkg::SR_ESUSP]  = esusp;
		status[flash_seq_pkg::SR_EFAIL]  = efail;
		status[flash_seq_pkg::SR_PFAIL]  = pfail;
		status[flash_seq_pkg::SR_LOCKED] = locked;
	end

	// bus decode, command sequencer and embedded algorithm
	always_comb begin
		next_state     = state;
		next_cyc       = cyc;
		next_pend_prog = pend_prog;
		next_esect     = esect;
		next_phase     = phase;
		next_wptr      = wptr;
		next_timer     = timer;
		next_scnt      = scnt;
		next_rec_cnt   = rec_cnt;
		next_stat_ovl  = stat_ovl;
		next_ssr_mode  = ssr_mode;
		next_ovl_mode  = ovl_mode;
		next_efail     = efail;
		next_pfail     = pfail;
		next_locked    = locked;
		next_dyn_prot  = dyn_prot;
		next_pers_prot = pers_prot;
		next_addr_reg  = addr_reg;
		next_prog_word = prog_word;
		next_prog_data = prog_data;
		next_prdata    = prdata;
		next_pslverr   = pslverr;
		mem_we         = 1'b0;
		mem_wa         = {esect, wptr};
		mem_wd         = flash_seq_pkg::PREPROG_WORD;
		cmd            = pwdata[7:0];
		is555          = addr_reg == flash_seq_pkg::ADDR_UNLOCK1;
		is2aa          = addr_reg == flash_seq_pkg::ADDR_UNLOCK2;
		tsect          = sector_of(addr_reg);
		wr_cyc         = psel && penable && pwrite && paddr == flash_seq_pkg::OFF_WRITE_CYCLE &&
			rec_cnt == 16'h0000; // commands wait out recovery

		// recovery after hardware reset
		if (rec_cnt != 16'h0000) begin
			next_rec_cnt = rec_cnt - 16'h0001;
		end

		// plain register writes in the access phase
		if (psel && penable && pwrite) begin
			if (paddr == flash_seq_pkg::OFF_ADDRESS) begin
				next_addr_reg = pwdata[11:0];
			end else if (paddr == flash_seq_pkg::OFF_PROTECT) begin
				next_dyn_prot  = pwdata[SECTORS-1:0];
				next_pers_prot = pwdata[2*SECTORS-1:SECTORS];
			end
		end

		// read data and error are captured in the setup phase
		if (psel && !penable) begin
			next_pslverr = 1'b0;
			next_prdata  = 32'h0000_0000;
			if (paddr == flash_seq_pkg::OFF_WRITE_CYCLE) begin
				next_prdata = 32'h0000_0000;
			end else if (paddr == flash_seq_pkg::OFF_ADDRESS) begin
				next_prdata = {20'h0_0000, addr_reg};
			end else if (paddr == flash_seq_pkg::OFF_READ_DATA) begin
				// suspended sector words are whatever the halted erase left
				next_prdata = {16'h0000, stat_ovl ? status : mem[word_of(addr_reg)]};
			end else if (paddr == flash_seq_pkg::OFF_STATUS) begin
				next_prdata = {16'h0000, status};
			end else if (paddr == flash_seq_pkg::OFF_PROTECT) begin
				next_prdata = 32'({pers_prot, dyn_prot});
			end else if (paddr == flash_seq_pkg::OFF_MODE) begin
				next_prdata = {25'h000_0000, ovl_mode, ssr_mode, rec_cnt != 16'h0000, 1'b0, state};
			end else begin
				next_pslverr = 1'b1;
			end
		end

		// a read of the array port consumes the one-shot status overlay
		if (psel && penable && !pwrite && paddr == flash_seq_pkg::OFF_READ_DATA) begin
			next_stat_ovl = 1'b0;
		end

		// embedded algorithm progress
		case (state)
			flash_seq_pkg::ST_PREPROG, flash_seq_pkg::ST_ERASE: begin
				if (timer != 16'h0000) begin
					next_timer = timer - 16'h0001;
				end else begin
					// zeros first, then all ones, word by word
					mem_we     = 1'b1;
					mem_wd     = (state == flash_seq_pkg::ST_ERASE) ?
						flash_seq_pkg::ERASED_WORD : flash_seq_pkg::PREPROG_WORD;
					next_timer = 16'(STEP_CYCLES - 1);
					next_wptr  = wptr + SW_W'(1);
					if (wptr == LAST_WORD) begin
						next_wptr = '0;
						if (state == flash_seq_pkg::ST_PREPROG) begin
							next_state = flash_seq_pkg::ST_ERASE;
						end else begin
							next_state = flash_seq_pkg::ST_IDLE;
							next_efail = 1'b0;
						end
					end
				end
			end
			flash_seq_pkg::ST_SUSPENDING: begin
				if (scnt != 16'h0000) begin
					next_scnt = scnt - 16'h0001;
				end else begin
					next_state = flash_seq_pkg::ST_SUSPENDED;
				end
			end
			flash_seq_pkg::ST_PROG, flash_seq_pkg::ST_SUSP_PROG: begin
				if (timer != 16'h0000) begin
					next_timer = timer - 16'h0001;
				end else begin
					// programming can only clear bits
					mem_we     = 1'b1;
					mem_wa     = prog_word;
					mem_wd     = mem[prog_word] & prog_data;
					next_pfail = 1'b0;
					next_state = (state == flash_seq_pkg::ST_SUSP_PROG) ?
						flash_seq_pkg::ST_SUSPENDED : flash_seq_pkg::ST_IDLE;
				end
			end
			default: begin
			end
		endcase

		// command cycles written by the host
		if (wr_cyc) begin
			next_cyc = 3'd0;
			if (cmd == flash_seq_pkg::CMD_STATUS_READ && is555) begin
				next_stat_ovl = 1'b1; // valid in every state
			end else if (state == flash_seq_pkg::ST_PREPROG || state == flash_seq_pkg::ST_ERASE) begin
				// only suspend gets through while erasing
				if (cmd == flash_seq_pkg::CMD_SUSPEND) begin
					next_state = flash_seq_pkg::ST_SUSPENDING;
					next_scnt  = 16'(flash_seq_pkg::ERASE_SUSPEND_CYC - 1);
					next_phase = state == flash_seq_pkg::ST_ERASE;
				end
			end else if (state == flash_seq_pkg::ST_SUSP_FAIL) begin
				// failed program parks until status is cleared
				if ((cmd == flash_seq_pkg::CMD_STATUS_CLEAR && is555) ||
					cmd == flash_seq_pkg::CMD_RESET) begin
					next_state  = flash_seq_pkg::ST_SUSPENDED;
					next_efail  = 1'b0;
					next_pfail  = 1'b0;
					next_locked = 1'b0;
				end
			end else if (state == flash_seq_pkg::ST_IDLE || state == flash_seq_pkg::ST_SUSPENDED) begin
				if (pend_prog) begin
					next_pend_prog = 1'b0;
					if (is_protected(dyn_prot, pers_prot, tsect)) begin
						next_pfail  = 1'b1;
						next_locked = 1'b1;
						if (esusp) begin
							next_state = flash_seq_pkg::ST_SUSP_FAIL;
						end
					end else if (esusp && tsect == esect) begin
						next_pfail = 1'b1;
						next_state = flash_seq_pkg::ST_SUSP_FAIL;
					end else begin
						next_state     = esusp ? flash_seq_pkg::ST_SUSP_PROG :
							flash_seq_pkg::ST_PROG;
						next_prog_word = word_of(addr_reg);
						next_prog_data = pwdata[15:0];
						next_timer     = 16'(PROG_CYCLES - 1);
						next_locked    = 1'b0;
					end
				end else if (cyc == 3'd5 && cmd == flash_seq_pkg::CMD_SECTOR_ERASE) begin
					// sixth cycle of the erase sequence names the sector
					if (esusp) begin
						next_efail = 1'b1; // no new erase while one is parked
					end else if (is_protected(dyn_prot, pers_prot, tsect)) begin
						next_efail  = 1'b1;
						next_locked = 1'b1;
					end else begin
						next_state  = flash_seq_pkg::ST_PREPROG;
						next_esect  = tsect;
						next_wptr   = '0;
						next_timer  = 16'(STEP_CYCLES - 1);
						next_locked = 1'b0;
					end
				end else if (cmd == flash_seq_pkg::CMD_RESUME && esusp && cyc == 3'd0) begin
					next_state = next_phase_state(phase);
				end else if (cmd == flash_seq_pkg::CMD_UNLOCK1 && is555 &&
					(cyc == 3'd0 || cyc == 3'd3)) begin
					next_cyc = cyc + 3'd1;
				end else if (cmd == flash_seq_pkg::CMD_UNLOCK2 && is2aa &&
					(cyc == 3'd1 || cyc == 3'd4)) begin
					next_cyc = cyc + 3'd1;
				end else if (cyc == 3'd2) begin
					if (cmd == flash_seq_pkg::CMD_ERASE_SETUP && is555) begin
						next_cyc = 3'd3;
					end else if (cmd == flash_seq_pkg::CMD_PROGRAM && is555) begin
						next_pend_prog = 1'b1;
					end else if (cmd == flash_seq_pkg::CMD_SSR_ENTRY && is555) begin
						next_ssr_mode = 1'b1;
					end else if (cmd == flash_seq_pkg::CMD_OVERLAY_ENTRY && is555 && !esusp) begin
						next_ovl_mode = 1'b1; // refused while suspended
					end
				end else if (cmd == flash_seq_pkg::CMD_STATUS_CLEAR && is555) begin
					next_efail  = 1'b0;
					next_pfail  = 1'b0;
					next_locked = 1'b0;
				end else if (cmd == flash_seq_pkg::CMD_RESET) begin
					next_efail    = 1'b0; // exits overlays and clears results
					next_pfail    = 1'b0;
					next_locked   = 1'b0;
					next_ssr_mode = 1'b0;
					next_ovl_mode = 1'b0;
				end
			end
		end
	end

	// erase phase to return to on resume
	function automatic flash_seq_pkg::ctl_state_t next_phase_state(input logic erasing);
		return erasing ? flash_seq_pkg::ST_ERASE : flash_seq_pkg::ST_PREPROG;
	endfunction

	// controller registers; reset aborts any erase at once
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state     <= flash_seq_pkg::ST_IDLE;
			cyc       <= 3'd0;
			pend_prog <= 1'b0;
			esect     <= '0;
			phase     <= 1'b0;
			wptr      <= '0;
			timer     <= 16'h0000;
			scnt      <= 16'h0000;
			rec_cnt   <= 16'(flash_seq_pkg::RESET_RECOVERY_CYC);
			stat_ovl  <= 1'b0;
			ssr_mode  <= 1'b0;
			ovl_mode  <= 1'b0;
			efail     <= 1'b0;
			pfail     <= 1'b0;
			locked    <= 1'b0;
			dyn_prot  <= '0;
			pers_prot <= '0;
			addr_reg  <= 12'h000;
			prog_word <= '0;
			prog_data <= 16'h0000;
			prdata    <= 32'h0000_0000;
			pslverr   <= 1'b0;
		end else begin
			state     <= next_state;
			cyc       <= next_cyc;
			pend_prog <= next_pend_prog;
			esect     <= next_esect;
			phase     <= next_phase;
			wptr      <= next_wptr;
			timer     <= next_timer;
			scnt      <= next_scnt;
			rec_cnt   <= next_rec_cnt;
			stat_ovl  <= next_stat_ovl;
			ssr_mode  <= next_ssr_mode;
			ovl_mode  <= next_ovl_mode;
			efail     <= next_efail;
			pfail     <= next_pfail;
			locked    <= next_locked;
			dyn_prot  <= next_dyn_prot;
			pers_prot <= next_pers_prot;
			addr_reg  <= next_addr_reg;
			prog_word <= next_prog_word;
			prog_data <= next_prog_data;
			prdata    <= next_prdata;
			pslverr   <= next_pslverr;
		end
	end

	// flash array, contents survive reset
	always_ff @(posedge clock) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end

endmodule // sector_erase_suspend_sequencer

// ### sector_erase_suspend_sequencer_props.sv
// port checker for the sector erase and suspend sequencer
`timescale 1ns/1ps

module seq_port_props (
	// clock and reset
	input wire logic        clock,
	input wire logic        reset_n,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	logic acc;
	logic rd_st;
	logic mapped;

	// access phase and address decode
	assign acc    = psel && penable;
	assign rd_st  = acc && !pwrite && paddr == flash_seq_pkg::OFF_STATUS;
	assign mapped = paddr <= flash_seq_pkg::OFF_MODE && paddr[1:0] == 2'b00;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_no_wait: assert property (psel && !penable |=> pready) else $error("wait state seen");
	a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("mapped access refused");
	a_data_holds: assert property (acc |=> $stable(prdata)) else $error("read data moved");
	a_cycle_reads_zero: assert property (acc && !pwrite && paddr == flash_seq_pkg::OFF_WRITE_CYCLE
		|-> prdata == 32'h0) else $error("write cycle register not zero");
	a_status_spare: assert property (rd_st |-> prdata[31:8] == 24'h0 && prdata[3:2] == 2'b00
		&& !prdata[0]) else $error("spare status bits set");
	a_susp_ready: assert property (rd_st && prdata[flash_seq_pkg::SR_ESUSP]
		&& !prdata[flash_seq_pkg::SR_READY] |-> !prdata[flash_seq_pkg::SR_LOCKED])
		else $error("locked flag during suspended program");
	a_lock_cause: assert property (rd_st && prdata[flash_seq_pkg::SR_LOCKED]
		|-> prdata[flash_seq_pkg::SR_EFAIL] || prdata[flash_seq_pkg::SR_PFAIL])
		else $error("locked flag without failure");
	a_reset_quiet: assert property ($rose(reset_n) |-> prdata == 32'h0 && !pslverr)
		else $error("outputs not cleared by reset");

	c_suspended: cover property (rd_st && prdata[flash_seq_pkg::SR_ESUSP]);
	c_locked: cover property (rd_st && prdata[flash_seq_pkg::SR_LOCKED]);
	c_refused: cover property (acc && pslverr);
	c_susp_prog: cover property (rd_st && prdata[flash_seq_pkg::SR_ESUSP] &&
		!prdata[flash_seq_pkg::SR_READY]);
endmodule // seq_port_props

bind sector_erase_suspend_sequencer seq_port_props chk_u (
	.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
);

// ### flash_host_model.sv
// host memory controller model: apb master issuing flash command cycles
`timescale 1ns/1ps

module flash_host_model (
	// clock
	input  wire logic        clock,
	// apb master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	// read results for the bench
	output logic             rd_done,
	output logic      [31:0] rd_word,
	output logic             timed_out
);
	int gap = 0; // idle cycles before each transfer

	initial begin
		{psel, penable, pwrite, rd_done, timed_out} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rd_word = 32'h0;
	end

	// one transfer, held until pready is sampled high or 16 cycles pass; released bus shows inverted address and data
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic chk, output logic [31:0] q);
		int k;
		repeat (gap + 1) @(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 16);
		q = prdata;
		timed_out <= (pready !== 1'b1);
		{psel, penable} <= 2'b00;
		paddr <= ~a;
		pwdata <= ~d;
		rd_word <= prdata;
		rd_done <= chk;
		@(posedge clock);
		rd_done <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, 1'b0, q);
	endtask

	// one flash bus write: address then command byte
	task automatic cmd8(input logic [11:0] fa, input logic [7:0] c);
		wr(flash_seq_pkg::OFF_ADDRESS, {20'h0, fa});
		wr(flash_seq_pkg::OFF_WRITE_CYCLE, {24'h0, c});
	endtask

	task automatic unlock;
		cmd8(flash_seq_pkg::ADDR_UNLOCK1, flash_seq_pkg::CMD_UNLOCK1);
		cmd8(flash_seq_pkg::ADDR_UNLOCK2, flash_seq_pkg::CMD_UNLOCK2);
	endtask

	// full erase sequence, always sent whole, also after a reset
	task automatic erase_seq(input logic [11:0] sa);
		unlock();
		cmd8(flash_seq_pkg::ADDR_UNLOCK1, flash_seq_pkg::CMD_ERASE_SETUP);
		unlock();
		cmd8(sa, flash_seq_pkg::CMD_SECTOR_ERASE);
	endtask

	task automatic entry(input logic [7:0] c);
		unlock();
		cmd8(flash_seq_pkg::ADDR_UNLOCK1, c);
	endtask

	task automatic prog_seq(input logic [11:0] fa, input logic [15:0] d);
		entry(flash_seq_pkg::CMD_PROGRAM);
		wr(flash_seq_pkg::OFF_ADDRESS, {20'h0, fa});
		wr(flash_seq_pkg::OFF_WRITE_CYCLE, {16'h0, d});
	endtask
endmodule // flash_host_model

// ### sector_erase_suspend_sequencer_tb_top.sv
// self-checking bench for the sector erase and suspend sequencer
`timescale 1ns/1ps

module sector_erase_suspend_sequencer_tb_top;
	typedef struct { logic [7:0] addr; logic [31:0] val; logic [31:0] mask; } note_t;
	logic        clock;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rd_done;
	logic [31:0] rd_word;
	logic        timed_out;
	logic [31:0] q;
	logic [11:0] sb;
	logic [11:0] ub;
	logic [11:0] w;
	logic [15:0] dv;
	note_t       notes[$];
	note_t       e;
	int          errors = 0;
	int          n_tests = 0;
	int          n;
	int          cyc = 0;
	int          t0;

	sector_erase_suspend_sequencer #(.STEP_CYCLES(4), .PROG_CYCLES(4)) dut_u (
		.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	flash_host_model host_u (
		.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .rd_done(rd_done),
		.rd_word(rd_word), .timed_out(timed_out));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// compare each checked read with the oldest note; cut a hung transfer short
	always @(posedge clock) begin
		cyc++;
		if (timed_out === 1'b1) begin
			errors++;
			tally_and_finish();
		end
		if (rd_done === 1'b1) begin
			e = notes.pop_front();
			n_tests++;
			if ((rd_word & e.mask) !== e.val) begin
				errors++;
				$display("MISMATCH reg %h exp %h seen %h", e.addr, e.val, rd_word & e.mask);
			end
		end
	end

	task automatic chk(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
		notes.push_back('{a, v, m});
		host_u.xfer(1'b0, a, 32'h0, 1'b1, q);
	endtask

	task automatic st(input logic [7:0] v);
		chk(flash_seq_pkg::OFF_STATUS, {24'h0, v}, 32'hf2);
	endtask

	task automatic mode(input logic [7:0] v, input logic [7:0] m);
		chk(flash_seq_pkg::OFF_MODE, {24'h0, v}, {24'h0, m});
	endtask

	task automatic fword(input logic [11:0] fa, input logic [15:0] v);
		host_u.wr(flash_seq_pkg::OFF_ADDRESS, {20'h0, fa});
		chk(flash_seq_pkg::OFF_READ_DATA, {16'h0, v}, 32'hffff);
	endtask

	task automatic sector_ok(input logic [11:0] b);
		for (int i = 0; i < 8; i++) fword(b + 12'(i), flash_seq_pkg::ERASED_WORD);
	endtask

	// poll status until ready, bounded
	task automatic poll;
		n = 0;
		do begin
			host_u.xfer(1'b0, flash_seq_pkg::OFF_STATUS, 32'h0, 1'b0, q);
			n++;
		end while (q[flash_seq_pkg::SR_READY] !== 1'b1 && n < 100);
		if (q[flash_seq_pkg::SR_READY] !== 1'b1) begin
			errors++;
			$display("MISMATCH ready exp 1 seen %b", q[flash_seq_pkg::SR_READY]);
			tally_and_finish();
		end
	endtask

	task automatic done_t(input int t);
		$display("test %0d finished", t);
	endtask

	initial begin
		reset_n = 1'b0;
		q = $urandom(8739);
		sb = 12'(($urandom % 4) * 8);
		ub = 12'(((sb / 8 + 1 + $urandom % 3) % 4) * 8);
		w = 12'($urandom % 8);
		dv = 16'($urandom);
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		repeat (12) @(posedge clock);
		// reset state and refusals
		st(8'h80);
		chk(8'h18, 32'h0, 32'hffffffff);
		// suspend with no erase running must change nothing
		host_u.cmd8(12'h0, flash_seq_pkg::CMD_SUSPEND);
		st(8'h80);
		done_t(0);
		// plain erase with a command ignored while busy
		host_u.gap = $urandom % 3;
		host_u.erase_seq(ub);
		st(8'h00);
		host_u.entry(flash_seq_pkg::CMD_OVERLAY_ENTRY);
		mode(8'h00, 8'h40);
		poll();
		st(8'h80);
		sector_ok(ub);
		done_t(1);
		// suspend, work while suspended, resume twice
		host_u.gap = 0;
		host_u.erase_seq(sb);
		host_u.cmd8(12'h0, flash_seq_pkg::CMD_SUSPEND);
		t0 = cyc;
		st(8'h00);
		poll();
		if (cyc - t0 > flash_seq_pkg::ERASE_SUSPEND_CYC + 8) begin
			errors++;
			$display("MISMATCH suspend cycles exp %0d seen %0d", flash_seq_pkg::ERASE_SUSPEND_CYC, cyc - t0);
		end
		st(8'hc0);
		host_u.entry(flash_seq_pkg::CMD_OVERLAY_ENTRY);
		mode(8'h04, 8'h47);
		host_u.entry(flash_seq_pkg::CMD_SSR_ENTRY);
		mode(8'h24, 8'h27);
		host_u.cmd8(12'h0, flash_seq_pkg::CMD_RESET);
		mode(8'h04, 8'h27);
		host_u.prog_seq(ub + w, dv);
		st(8'h40);
		poll();
		st(8'hc0);
		fword(ub + w, dv);
		host_u.prog_seq(sb + w, 16'h0000);
		poll();
		st(8'hd0);
		host_u.cmd8(flash_seq_pkg::ADDR_UNLOCK1, flash_seq_pkg::CMD_STATUS_CLEAR);
		st(8'hc0);
		mode(8'h04, 8'h07);
		host_u.cmd8(12'h0, flash_seq_pkg::CMD_RESUME);
		st(8'h00);
		host_u.cmd8(12'h0, flash_seq_pkg::CMD_RESUME);
		host_u.cmd8(12'h0, flash_seq_pkg::CMD_SUSPEND);
		poll();
		st(8'hc0);
		host_u.cmd8(12'h0, flash_seq_pkg::CMD_RESUME);
		poll();
		st(8'h80);
		sector_ok(sb);
		fword(ub + w, dv);
		done_t(2);
		// protected sector, dynamic then persistent bit
		for (int k = 0; k < 2; k++) begin
			host_u.wr(flash_seq_pkg::OFF_PROTECT, 32'h1 << (sb[4:3] + 4 * k));
			host_u.erase_seq(sb);
			st(8'ha2);
			host_u.cmd8(flash_seq_pkg::ADDR_UNLOCK1, flash_seq_pkg::CMD_STATUS_CLEAR);
			st(8'h80);
		end
		host_u.wr(flash_seq_pkg::OFF_PROTECT, 32'h0);
		fword(ub + w, dv);
		done_t(3);
		// hardware reset in mid erase, then the full sequence again
		host_u.erase_seq(ub);
		repeat (5) @(posedge clock);
		reset_n <= 1'b0;
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		mode(8'h10, 8'h17);
		repeat (flash_seq_pkg::RESET_RECOVERY_CYC) @(posedge clock);
		mode(8'h00, 8'h17);
		st(8'h80);
		host_u.erase_seq(ub);
		poll();
		sector_ok(ub);
		done_t(4);
		tally_and_finish();
	end
endmodule // sector_erase_suspend_sequencer_tb_top
